// >>> pkg/dps_pkg.sv
// Package for the dual-port memory and flag host controller.
// Assumes one 40 MHz system clock and pins sampled synchronously to it.
package dps_pkg;

    // ------------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int FLAG_CNT = 8;
    localparam int FLAG_IDX_W = 3;
    localparam int TMR_W = 8;

    // ------------------------------------------------------------------
    // Pin timing in nanoseconds and derived cycle counts
    // ------------------------------------------------------------------
    localparam int T_WP_NS = 60;
    localparam int T_ACC_NS = 70;
    localparam int T_SWRD_NS = 10;
    localparam int T_SPS_NS = 10;

    // Least times round up to whole cycles and never fall below one.
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [TMR_W-1:0] C_WP = TMR_W'(min_cycles(T_WP_NS));
    localparam logic [TMR_W-1:0] C_ACC = TMR_W'(min_cycles(T_ACC_NS));
    localparam logic [TMR_W-1:0] C_GAP =
        TMR_W'(min_cycles((T_SWRD_NS > T_SPS_NS) ? T_SWRD_NS : T_SPS_NS));

    // ------------------------------------------------------------------
    // Flag values and reset values
    // ------------------------------------------------------------------
    localparam logic FLAG_TAKE = 1'b0;
    localparam logic FLAG_FREE = 1'b1;
    localparam logic [FLAG_IDX_W-1:0] FLAG_LAST = 3'h7;
    localparam logic [FLAG_IDX_W-1:0] FLAG_IDX_RESET = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // ------------------------------------------------------------------
    // Steps of a flag acquire
    // ------------------------------------------------------------------
    localparam logic [1:0] STEP_REQ = 2'h0;
    localparam logic [1:0] STEP_CHECK = 2'h1;
    localparam logic [1:0] STEP_WITHDRAW = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_MEM_RD = 3'h0,
        OP_MEM_WR = 3'h1,
        OP_FLAG_RD = 3'h2,
        OP_ACQUIRE = 3'h3,
        OP_RELEASE = 3'h4
    } dps_op_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_ACTIVE = 5'h04,
        ST_HOLD = 5'h08,
        ST_GAP = 5'h10
    } dps_state_e;

    typedef struct packed {
        dps_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dps_cmd_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic granted;
        logic withdrawn;
    } dps_rsp_s;

    typedef struct packed {
        logic mem_select_n;
        logic flag_select_n;
        logic out_enable_n;
        logic rw_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
    } dps_pins_s;

    localparam dps_pins_s PINS_RESET = '{1'b1, 1'b1, 1'b1, 1'b1, ADDR_RESET, DATA_RESET, 1'b0};

endpackage

// >>> design/dps_step_timer.sv
// Down counter that times the active and gap phases of a pin access.
// Assumes the loader gives a count of at least one.
`timescale 1ns/1ps
`default_nettype none
module dps_step_timer
    import dps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [TMR_W-1:0] count,
    output logic expire
);
    logic [TMR_W-1:0] cnt_reg;
    logic [TMR_W-1:0] cnt_next;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign expire = (cnt_reg == TMR_W'(1));
    assign cnt_next = load ? count : ((cnt_reg != '0) ? cnt_reg - TMR_W'(1) : cnt_reg);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // dps_step_timer
`default_nettype wire

// >>> design/dps_host.sv
// Host controller driving one port of a dual-port memory with eight flags.
// Assumes the port pins are sampled synchronously to clk_sys at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module dps_host
    import dps_pkg::*;
#(
    parameter int ACQ_TRIES = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire dps_pkg::dps_cmd_s cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output dps_pkg::dps_rsp_s rsp,
    output logic init_done,
    output dps_pkg::dps_pins_s pins,
    input wire logic [dps_pkg::DATA_W-1:0] dq_i
);
    import dps_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ACQ_TRIES < 1 || ACQ_TRIES > 255) begin : g_bad_tries
        $error("ACQ_TRIES must lie between 1 and 255.");
    end

    localparam logic [7:0] TRIES = 8'(ACQ_TRIES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dps_state_e state_reg, state_next;
    dps_op_e op_reg, op_next;
    logic [1:0] step_reg, step_next;
    logic [7:0] tries_reg, tries_next;
    logic init_busy_reg, init_busy_next;
    logic [FLAG_IDX_W-1:0] init_idx_reg, init_idx_next;
    logic acc_wr_reg, acc_wr_next;
    logic acc_flag_reg, acc_flag_next;
    logic [ADDR_W-1:0] acc_addr_reg, acc_addr_next;
    logic [DATA_W-1:0] acc_data_reg, acc_data_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    dps_rsp_s rsp_reg, rsp_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic cmd_ready_reg, cmd_ready_next;
    logic init_done_reg;
    dps_pins_s pins_reg, pins_next;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic tmr_expire;

    // Flag address carries only the low three bits; the rest stay zero.
    function automatic logic [ADDR_W-1:0] flag_addr(input logic [FLAG_IDX_W-1:0] idx);
        return {{(ADDR_W - FLAG_IDX_W){1'b0}}, idx};
    endfunction

    // A flag write places its value on every data bit, bit 0 being the one used.
    function automatic logic [DATA_W-1:0] flag_data(input logic val);
        return {DATA_W{val}};
    endfunction

    // ------------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------------
    dps_step_timer u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .count(tmr_count),
        .expire(tmr_expire)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        tries_next = tries_reg;
        init_busy_next = init_busy_reg;
        init_idx_next = init_idx_reg;
        acc_wr_next = acc_wr_reg;
        acc_flag_next = acc_flag_reg;
        acc_addr_next = acc_addr_reg;
        acc_data_next = acc_data_reg;
        rdata_next = rdata_reg;
        rsp_next = rsp_reg;
        rsp_valid_next = 1'b0;
        tmr_load = 1'b0;
        tmr_count = C_GAP;
        case (state_reg)
            ST_IDLE: begin
                if (init_busy_reg) begin
                    // Power-up: free every flag from this side.
                    state_next = ST_SETUP;
                    acc_wr_next = 1'b1;
                    acc_flag_next = 1'b1;
                    acc_addr_next = flag_addr(init_idx_reg);
                    acc_data_next = flag_data(FLAG_FREE);
                end else if (cmd_valid && cmd_ready_reg) begin
                    state_next = ST_SETUP;
                    op_next = cmd.op;
                    step_next = STEP_REQ;
                    tries_next = TRIES;
                    acc_flag_next = (cmd.op == OP_FLAG_RD) || (cmd.op == OP_ACQUIRE)
                        || (cmd.op == OP_RELEASE);
                    acc_wr_next = (cmd.op == OP_MEM_WR) || (cmd.op == OP_ACQUIRE)
                        || (cmd.op == OP_RELEASE);
                    acc_addr_next = acc_flag_next ? flag_addr(cmd.addr[FLAG_IDX_W-1:0])
                        : cmd.addr;
                    case (cmd.op)
                        OP_ACQUIRE: acc_data_next = flag_data(FLAG_TAKE);
                        OP_RELEASE: acc_data_next = flag_data(FLAG_FREE);
                        default: acc_data_next = cmd.wdata;
                    endcase
                end
            end
            ST_SETUP: begin
                state_next = ST_ACTIVE;
                tmr_load = 1'b1;
                tmr_count = acc_wr_reg ? C_WP : C_ACC;
            end
            ST_ACTIVE: begin
                if (tmr_expire) begin
                    state_next = ST_HOLD;
                    if (!acc_wr_reg) begin
                        rdata_next = dq_i;
                    end
                end
            end
            ST_HOLD: begin
                // Selects stay low here so the strobe rises inside the access.
                state_next = ST_GAP;
                tmr_load = 1'b1;
                tmr_count = C_GAP;
            end
            ST_GAP: begin
                if (tmr_expire) begin
                    state_next = ST_IDLE;
                    if (init_busy_reg) begin
                        if (init_idx_reg == FLAG_LAST) begin
                            init_busy_next = 1'b0;
                        end else begin
                            init_idx_next = init_idx_reg + 3'h1;
                        end
                    end else if (op_reg == OP_ACQUIRE && step_reg == STEP_REQ) begin
                        // Write first, then read back.
                        state_next = ST_SETUP;
                        step_next = STEP_CHECK;
                        acc_wr_next = 1'b0;
                    end else if (op_reg == OP_ACQUIRE && step_reg == STEP_CHECK) begin
                        if (rdata_reg[0] == FLAG_TAKE) begin
                            rsp_valid_next = 1'b1;
                            rsp_next = '{rdata_reg, 1'b1, 1'b0};
                        end else if (tries_reg > 8'h01) begin
                            // Fresh read after the selects were dropped.
                            state_next = ST_SETUP;
                            tries_next = tries_reg - 8'h01;
                        end else begin
                            state_next = ST_SETUP;
                            step_next = STEP_WITHDRAW;
                            acc_wr_next = 1'b1;
                            acc_data_next = flag_data(FLAG_FREE);
                        end
                    end else begin
                        rsp_valid_next = 1'b1;
                        rsp_next = '{rdata_reg, 1'b0, step_reg == STEP_WITHDRAW};
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Pin decode from the next state
    // ------------------------------------------------------------------
    wire sel_on = (state_next == ST_SETUP) || (state_next == ST_ACTIVE)
        || (state_next == ST_HOLD);
    wire drive_on = ((state_next == ST_ACTIVE) || (state_next == ST_HOLD)) && acc_wr_next;

    assign pins_next.mem_select_n = !(sel_on && !acc_flag_next);
    assign pins_next.flag_select_n = !(sel_on && acc_flag_next);
    assign pins_next.out_enable_n = !((state_next == ST_ACTIVE) && !acc_wr_next);
    assign pins_next.rw_n = !((state_next == ST_ACTIVE) && acc_wr_next);
    assign pins_next.addr = sel_on ? acc_addr_next : ADDR_RESET;
    assign pins_next.dq_o = drive_on ? acc_data_next : DATA_RESET;
    assign pins_next.dq_oe = drive_on;
    assign cmd_ready_next = (state_next == ST_IDLE) && !init_busy_next;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_MEM_RD;
            step_reg <= STEP_REQ;
            tries_reg <= 8'h00;
            init_busy_reg <= 1'b1;
            init_idx_reg <= FLAG_IDX_RESET;
            acc_wr_reg <= 1'b0;
            acc_flag_reg <= 1'b0;
            acc_addr_reg <= ADDR_RESET;
            acc_data_reg <= DATA_RESET;
            rdata_reg <= DATA_RESET;
            rsp_reg <= '0;
            rsp_valid_reg <= 1'b0;
            cmd_ready_reg <= 1'b0;
            init_done_reg <= 1'b0;
            pins_reg <= PINS_RESET;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            tries_reg <= tries_next;
            init_busy_reg <= init_busy_next;
            init_idx_reg <= init_idx_next;
            acc_wr_reg <= acc_wr_next;
            acc_flag_reg <= acc_flag_next;
            acc_addr_reg <= acc_addr_next;
            acc_data_reg <= acc_data_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
            rsp_valid_reg <= rsp_valid_next;
            cmd_ready_reg <= cmd_ready_next;
            init_done_reg <= !init_busy_next;
            pins_reg <= pins_next;
        end
    end

    assign cmd_ready = cmd_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp = rsp_reg;
    assign init_done = init_done_reg;
    assign pins = pins_reg;
endmodule // dps_host
`default_nettype wire

// >>> verif/dps_host_chk.sv
// Checker of the host controller's port behaviour.
// Assumes it is bound into dps_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dps_host_chk
    import dps_pkg::*;
#(
    parameter int ACQ_TRIES = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire dps_pkg::dps_cmd_s cmd,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire dps_pkg::dps_rsp_s rsp,
    input wire logic init_done,
    input wire dps_pkg::dps_pins_s pins,
    input wire logic [dps_pkg::DATA_W-1:0] dq_i
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sel_excl_a: assert property (pins.mem_select_n || pins.flag_select_n)
        else $error("both selects low");
    idle_float_a: assert property (pins.dq_oe |-> !pins.mem_select_n || !pins.flag_select_n)
        else $error("data driven while port idle");
    read_no_drive_a: assert property (!pins.out_enable_n |-> pins.rw_n && !pins.dq_oe)
        else $error("drive or write during read");
    flag_addr_a: assert property (!pins.flag_select_n |-> pins.addr[11:3] == 9'h000)
        else $error("high address bits set on flag access");
    write_pulse_a: assert property ($fell(pins.rw_n) |-> !pins.rw_n [*3] ##1 pins.rw_n)
        else $error("write pulse length wrong");
    write_edge_a: assert property ($rose(pins.rw_n) |-> pins.dq_oe &&
        (!pins.mem_select_n || !pins.flag_select_n)) else $error("select dropped before strobe rise");
    poll_gap_a: assert property ($rose(pins.out_enable_n) |=> pins.mem_select_n &&
        pins.flag_select_n) else $error("no deselect between reads");
    take_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready &&
        (!pins.mem_select_n || !pins.flag_select_n)) else $error("command take wrong");
    wr_latency_a: assert property (cmd_valid && cmd_ready && cmd.op == OP_MEM_WR |->
        ##7 rsp_valid) else $error("memory write answer late");
    rsp_pulse_a: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
        else $error("answer pulse wrong");
    init_gate_a: assert property (!init_done |-> !cmd_ready)
        else $error("ready before flag init");
    init_keep_a: assert property (init_done |=> init_done)
        else $error("init done fell");
    cover property (rsp_valid && rsp.granted);
    cover property (rsp_valid && rsp.withdrawn);
    cover property (!pins.flag_select_n && !pins.out_enable_n);
endmodule // dps_host_chk
bind dps_host dps_host_chk #(.ACQ_TRIES(ACQ_TRIES)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .init_done(init_done), .pins(pins), .dq_i(dq_i));
`default_nettype wire

// >>> verif/dps_dev_model.sv
// Model of the dual-port memory with eight flags, near port on pins.
// Assumes pins are registered on clk_sys; the far port is a simple flag write strobe.
`timescale 1ns/1ps
`default_nettype none
module dps_dev_model
    import dps_pkg::*;
(
    input wire logic clk_sys,
    input wire dps_pkg::dps_pins_s pins,
    output logic [dps_pkg::DATA_W-1:0] dq_i,
    input wire logic far_wr,
    input wire logic [dps_pkg::FLAG_IDX_W-1:0] far_idx,
    input wire logic far_bit,
    output logic [dps_pkg::FLAG_CNT-1:0] far_flag
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:4095];
    logic [FLAG_CNT-1:0] req_l, req_r, own_l, own_r, nl, nr;
    logic [DATA_W-1:0] rd_latch, last;
    logic rw_q, rd_q, fl_rd;
    wire [FLAG_IDX_W-1:0] fidx = pins.addr[2:0];
    wire rd_on = !pins.out_enable_n && pins.rw_n && (pins.mem_select_n != pins.flag_select_n);
    assign far_flag = ~own_r;
    assign dq_i = rd_on ? (pins.flag_select_n ? mem[pins.addr] : rd_latch) : ~last;
    initial begin
        req_l = '0;
        own_l = '1;
        req_r = '1;
        own_r = '0;
        rw_q = 1'b1;
        rd_q = 1'b0;
        last = 8'h00;
        rd_latch = 8'h00;
    end
    // ------------------------------------------------------------
    // Access and flag logic
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (pins.rw_n && !rw_q && !pins.mem_select_n && pins.flag_select_n) begin
            mem[pins.addr] = pins.dq_o;
        end
        nl = req_l;
        nr = req_r;
        if (pins.rw_n && !rw_q && !pins.flag_select_n && pins.mem_select_n) begin
            nl[fidx] = pins.dq_o[0];
        end
        if (far_wr) begin
            nr[far_idx] = far_bit;
        end
        for (int i = 0; i < FLAG_CNT; i++) begin
            if (own_l[i] && nl[i]) begin
                own_l[i] = 1'b0;
                own_r[i] = !nr[i];
            end else if (own_r[i] && nr[i]) begin
                own_r[i] = 1'b0;
                own_l[i] = !nl[i];
            end else if (!own_l[i] && !own_r[i]) begin
                own_l[i] = !nl[i];
                own_r[i] = nl[i] && !nr[i];
            end
        end
        req_l = nl;
        req_r = nr;
        fl_rd = !pins.flag_select_n && !pins.out_enable_n;
        if (fl_rd && !rd_q) begin
            rd_latch = {DATA_W{!own_l[fidx]}};
        end
        rd_q = fl_rd;
        if (rd_on) begin
            last = dq_i;
        end
        rw_q = pins.rw_n;
    end
endmodule // dps_dev_model
`default_nettype wire

// >>> verif/dps_host_bench.sv
// Self-checking bench of the host controller against the device model.
// Assumes the design package and the checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t %s", $time, msg); end end
module dps_host_bench;
    import dps_pkg::*;
    typedef struct packed {
        dps_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic chk_rd;
        logic [DATA_W-1:0] exp_rd;
    } dps_row_s;
    localparam dps_row_s ROWS [9] = '{
        '{OP_MEM_WR, 12'h000, 8'h5a, 1'b0, 8'h00},
        '{OP_MEM_WR, 12'hfff, 8'ha5, 1'b0, 8'h00},
        '{OP_MEM_RD, 12'h000, 8'h00, 1'b1, 8'h5a},
        '{OP_MEM_RD, 12'hfff, 8'h00, 1'b1, 8'ha5},
        '{OP_FLAG_RD, 12'h003, 8'h00, 1'b1, 8'hff},
        '{OP_ACQUIRE, 12'hff3, 8'h00, 1'b1, 8'h00},
        '{OP_FLAG_RD, 12'h803, 8'h00, 1'b1, 8'h00},
        '{OP_RELEASE, 12'h003, 8'h00, 1'b0, 8'h00},
        '{OP_FLAG_RD, 12'h7fb, 8'h00, 1'b1, 8'hff}};
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    dps_cmd_s cmd = '{OP_MEM_RD, 12'h000, 8'h00};
    logic cmd_ready, rsp_valid, init_done, far_bit = 1'b1, far_wr = 1'b0;
    logic [FLAG_IDX_W-1:0] far_idx = 3'h0;
    logic [FLAG_CNT-1:0] far_flag;
    logic [DATA_W-1:0] dq_i;
    dps_rsp_s rsp;
    dps_pins_s pins;
    int mismatches = 0;
    int tests_run = 0;
    always #12.5 clk_sys = ~clk_sys;
    dps_host #(.ACQ_TRIES(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .init_done(init_done), .pins(pins), .dq_i(dq_i));
    dps_dev_model u_dev (.clk_sys(clk_sys), .pins(pins), .dq_i(dq_i), .far_wr(far_wr),
        .far_idx(far_idx), .far_bit(far_bit), .far_flag(far_flag));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic run_cmd(input dps_op_e op, input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] wdata);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        cmd = '{op, addr, wdata};
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(rsp_valid, 1'b1, "no answer")
        @(negedge clk_sys);
    endtask
    task automatic far_write(input logic [FLAG_IDX_W-1:0] idx, input logic b);
        far_idx = idx;
        far_bit = b;
        far_wr = 1'b1;
        @(negedge clk_sys);
        far_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clk_sys);
        `CHK(pins, PINS_RESET, "pins in reset")
        `CHK(cmd_ready, 1'b0, "ready in reset")
        sys_rst = 1'b0;
        for (int i = 0; i < FLAG_CNT; i++) far_write(i[2:0], 1'b1);
        for (int n = 0; n < 200 && init_done !== 1'b1; n++) @(negedge clk_sys);
        `CHK(init_done, 1'b1, "init not done")
        `CHK(far_flag, 8'hff, "flags not free after init")
        foreach (ROWS[i]) begin
            run_cmd(ROWS[i].op, ROWS[i].addr, ROWS[i].wdata);
            if (ROWS[i].chk_rd) `CHK(rsp.rdata, ROWS[i].exp_rd, "row read value")
            if (ROWS[i].op == OP_ACQUIRE) `CHK(rsp.granted, 1'b1, "free flag not won")
        end
        far_write(3'h5, 1'b0);
        run_cmd(OP_ACQUIRE, 12'h005, 8'h00);
        `CHK({rsp.granted, rsp.withdrawn}, 2'b01, "owned flag not refused")
        `CHK(rsp.rdata, 8'hff, "refused read value")
        `CHK(far_flag[5], 1'b0, "far owner lost flag")
        far_write(3'h5, 1'b1);
        run_cmd(OP_FLAG_RD, 12'h005, 8'h00);
        `CHK({far_flag[5], rsp.rdata}, 9'h1ff, "flag not free after release")
        far_write(3'h6, 1'b0);
        fork
            run_cmd(OP_ACQUIRE, 12'h006, 8'h00);
            begin
                repeat (16) @(negedge clk_sys);
                far_write(3'h6, 1'b1);
            end
        join
        `CHK({rsp.granted, far_flag[6]}, 2'b11, "pending request not passed")
        run_cmd(OP_RELEASE, 12'h006, 8'h00);
        run_cmd(OP_MEM_RD, 12'h000, 8'h00);
        `CHK(rsp.rdata, 8'h5a, "memory disturbed by flags")
        print_verdict();
    end
    initial begin
        #(20000 * 25);
        mismatches++;
        print_verdict();
    end
endmodule // dps_host_bench
`default_nettype wire
